// >>> common/dcc_regs.vh
// Register map, field positions, reset values and timing counts of the converter control
//
// Function
// - Two independent channels, each holding an 8-bit code in its own value register.
// - Output equals reference voltage times code over 256, code 0 to 255.
// - Mode register is readable and writable as a whole byte or single bits.
// - Mode register resets to zero; enables at bits 5,4, modes at 1,0.
// - Enable bit 0 disables a channel's conversion, 1 enables it.
// - Mode bit 0 selects normal mode, 1 selects real-time output mode.
// - Real-time trigger is timer A compare for channel 0, timer B for channel 1.
// - Value registers reset to zero and are accessed only as whole bytes.
// - Real-time conversion starts on the timer event; software loads value before it.
// - Normal mode converts on every write to an enabled channel's value register.
// - Normal mode setup is mode, then code, then enable; enabling converts held code.
// - The last converted code stays applied until the channel's next conversion.
// - Real-time setup sets mode, code and enable before the timers start.
// - After setup, each timer event reapplies the value register's code.
// - Real-time outputs may be undefined until the first timer event converts.
// - Stop standby halts conversion and puts both analog outputs in high impedance.
// - Idle standby modes and subclock operation keep converting.
`ifndef DCC_REGS_VH
`define DCC_REGS_VH

`define DCC_ADDR_W 32
`define DCC_DATA_W 8
`define DCC_OFF_VALUE_CH0 32'hFFFFF280
`define DCC_OFF_VALUE_CH1 32'hFFFFF281
`define DCC_OFF_MODE 32'hFFFFF282
`define DCC_OFF_STATUS 32'hFFFFF283

`define DCC_MODE_MD0 0
`define DCC_MODE_MD1 1
`define DCC_MODE_CE0 4
`define DCC_MODE_CE1 5
`define DCC_MODE_IMPL_MASK 8'h33
`define DCC_MODE_RESET 8'h00
`define DCC_VALUE_RESET 8'h00
`define DCC_FULL_MASK 8'hFF

`define DCC_ST_VALID0 0
`define DCC_ST_VALID1 1
`define DCC_ST_SETTLED0 2
`define DCC_ST_SETTLED1 3
`define DCC_ST_CLASH0 4
`define DCC_ST_CLASH1 5
`define DCC_ST_STOP 7

`define DCC_CLK_PERIOD_NS 10
`define DCC_SETTLE_NS 3000
`define DCC_SETTLE_CYCLES (`DCC_SETTLE_NS / `DCC_CLK_PERIOD_NS)
`define DCC_SETTLE_W 9

`endif

// >>> rtl/dcc_sync.v
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module dcc_sync (
  input wire clk,
  input wire rst,
  input wire async_in,
  output reg sync_out
);
  reg stage1_reg;

  always @(posedge clk) begin
    if (rst) begin
      stage1_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/dcc_channel.v
// One converter channel: trigger selection and held output code
`timescale 1ns/1ns
`default_nettype none
module dcc_channel #(
  parameter W = 8
) (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire rt_mode,
  input wire stop,
  input wire value_wr,
  input wire [W-1:0] value_wdata,
  input wire [W-1:0] value_held,
  input wire timer_event,
  output reg [W-1:0] code_out,
  output reg code_valid,
  output reg conv_pulse
);
  reg enable_d_reg;
  reg rt_mode_d_reg;
  wire enable_rise;
  wire trig_normal;
  wire trig_rt;
  wire trig;
  wire [W-1:0] src;

  assign enable_rise = enable & ~enable_d_reg;
  // Write while enabled, or enable rising, converts
  assign trig_normal = ~rt_mode & enable & (value_wr | enable_rise);
  assign trig_rt = rt_mode & enable & timer_event;
  assign trig = ~stop & (trig_normal | trig_rt);
  // New write data goes straight through in normal mode
  assign src = (~rt_mode & value_wr) ? value_wdata : value_held;

  always @(posedge clk) begin
    if (rst) begin
      enable_d_reg <= 1'b0;
      rt_mode_d_reg <= 1'b0;
      code_out <= {W{1'b0}};
      code_valid <= 1'b0;
      conv_pulse <= 1'b0;
    end else begin
      enable_d_reg <= enable & ~stop;
      rt_mode_d_reg <= rt_mode;
      conv_pulse <= trig;
      if (trig) begin
        code_out <= src;
        code_valid <= 1'b1;
      end else if (stop || (rt_mode != rt_mode_d_reg)) begin
        code_valid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/dcc_top.v
// Two-channel 8-bit converter control: registers, triggers, standby and settling
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "dcc_regs.vh"
module dcc_top #(
  parameter CODE_W = 8,
  parameter SETTLE_CYCLES = `DCC_SETTLE_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire [`DCC_ADDR_W-1:0] bus_addr,
  input wire [`DCC_DATA_W-1:0] bus_wdata,
  input wire [`DCC_DATA_W-1:0] bus_wmask,
  input wire bus_wr,
  input wire bus_rd,
  output reg [`DCC_DATA_W-1:0] bus_rdata,
  input wire timer_a_compare_event,
  input wire timer_b_compare_event,
  input wire stop_mode_req,
  output wire [CODE_W-1:0] analog_out_ch0_code,
  output wire [CODE_W-1:0] analog_out_ch1_code,
  output reg analog_out_ch0_hiz,
  output reg analog_out_ch1_hiz,
  output wire conv_ch0_pulse,
  output wire conv_ch1_pulse
);
  reg [`DCC_DATA_W-1:0] mode_reg;
  reg [`DCC_DATA_W-1:0] mode_next;
  reg [CODE_W-1:0] value0_reg;
  reg [CODE_W-1:0] value1_reg;
  reg [1:0] clash_reg;
  reg [1:0] clash_next;
  reg [`DCC_SETTLE_W-1:0] settle_cnt_reg [0:1];
  reg [`DCC_DATA_W-1:0] rdata_next;
  wire stop_sync;
  wire sel_value0;
  wire sel_value1;
  wire sel_mode;
  wire sel_status;
  wire full_byte;
  wire value0_wr;
  wire value1_wr;
  wire mode_wr;
  wire status_wr;
  wire [1:0] valid;
  wire [1:0] settled;
  wire [1:0] conv_pulse;
  wire [1:0] timer_evt;
  wire [1:0] rt_mode;
  wire [`DCC_DATA_W-1:0] status_word;
  integer i;

  // Stop standby request from the power controller
  dcc_sync u_stop_sync (
    .clk(clk),
    .rst(rst),
    .async_in(stop_mode_req),
    .sync_out(stop_sync)
  );

  // Address decode
  assign sel_value0 = (bus_addr == `DCC_OFF_VALUE_CH0);
  assign sel_value1 = (bus_addr == `DCC_OFF_VALUE_CH1);
  assign sel_mode = (bus_addr == `DCC_OFF_MODE);
  assign sel_status = (bus_addr == `DCC_OFF_STATUS);
  assign full_byte = (bus_wmask == `DCC_FULL_MASK);

  // Value registers take whole-byte writes only
  assign value0_wr = bus_wr & sel_value0 & full_byte;
  assign value1_wr = bus_wr & sel_value1 & full_byte;
  assign mode_wr = bus_wr & sel_mode;
  assign status_wr = bus_wr & sel_status;

  // Byte or single-bit update of the mode register
  always @* begin
    mode_next = mode_reg;
    if (mode_wr) begin
      mode_next = ((mode_reg & ~bus_wmask) | (bus_wdata & bus_wmask))
        & `DCC_MODE_IMPL_MASK;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      mode_reg <= `DCC_MODE_RESET;
      value0_reg <= `DCC_VALUE_RESET;
      value1_reg <= `DCC_VALUE_RESET;
    end else begin
      mode_reg <= mode_next;
      if (value0_wr) begin
        value0_reg <= bus_wdata;
      end
      if (value1_wr) begin
        value1_reg <= bus_wdata;
      end
    end
  end

  // Timer A drives channel 0, timer B channel 1
  assign timer_evt[0] = timer_a_compare_event;
  assign timer_evt[1] = timer_b_compare_event;
  assign rt_mode[0] = mode_reg[`DCC_MODE_MD0];
  assign rt_mode[1] = mode_reg[`DCC_MODE_MD1];

  dcc_channel #(
    .W(CODE_W)
  ) u_ch0 (
    .clk(clk),
    .rst(rst),
    .enable(mode_reg[`DCC_MODE_CE0]),
    .rt_mode(rt_mode[0]),
    .stop(stop_sync),
    .value_wr(value0_wr),
    .value_wdata(bus_wdata),
    .value_held(value0_reg),
    .timer_event(timer_evt[0]),
    .code_out(analog_out_ch0_code),
    .code_valid(valid[0]),
    .conv_pulse(conv_pulse[0])
  );

  dcc_channel #(
    .W(CODE_W)
  ) u_ch1 (
    .clk(clk),
    .rst(rst),
    .enable(mode_reg[`DCC_MODE_CE1]),
    .rt_mode(rt_mode[1]),
    .stop(stop_sync),
    .value_wr(value1_wr),
    .value_wdata(bus_wdata),
    .value_held(value1_reg),
    .timer_event(timer_evt[1]),
    .code_out(analog_out_ch1_code),
    .code_valid(valid[1]),
    .conv_pulse(conv_pulse[1])
  );

  // Analog stage sets level = reference * code / 256 from the held code
  assign conv_ch0_pulse = conv_pulse[0];
  assign conv_ch1_pulse = conv_pulse[1];

  // High impedance outputs while stopped
  always @(posedge clk) begin
    if (rst) begin
      analog_out_ch0_hiz <= 1'b0;
      analog_out_ch1_hiz <= 1'b0;
    end else begin
      analog_out_ch0_hiz <= stop_sync;
      analog_out_ch1_hiz <= stop_sync;
    end
  end

  // Settling timer per channel after each conversion
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < 2; i = i + 1) begin
        settle_cnt_reg[i] <= {`DCC_SETTLE_W{1'b0}};
      end
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        if (conv_pulse[i]) begin
          settle_cnt_reg[i] <= SETTLE_CYCLES[`DCC_SETTLE_W-1:0];
        end else if (settle_cnt_reg[i] != {`DCC_SETTLE_W{1'b0}}) begin
          settle_cnt_reg[i] <= settle_cnt_reg[i] - 1'b1;
        end
      end
    end
  end

  assign settled[0] = valid[0] & (settle_cnt_reg[0] == {`DCC_SETTLE_W{1'b0}});
  assign settled[1] = valid[1] & (settle_cnt_reg[1] == {`DCC_SETTLE_W{1'b0}});

  // Sticky flag: value write in the cycle of a real-time trigger
  always @* begin
    clash_next = clash_reg;
    if (status_wr) begin
      clash_next = clash_reg & ~(bus_wmask[`DCC_ST_CLASH1:`DCC_ST_CLASH0]
        & bus_wdata[`DCC_ST_CLASH1:`DCC_ST_CLASH0]);
    end
    if (value0_wr && rt_mode[0] && timer_evt[0]) begin
      clash_next[0] = 1'b1;
    end
    if (value1_wr && rt_mode[1] && timer_evt[1]) begin
      clash_next[1] = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      clash_reg <= 2'b00;
    end else begin
      clash_reg <= clash_next;
    end
  end

  assign status_word = {stop_sync, 1'b0, clash_reg, settled, valid};

  // Read data one cycle after the read strobe
  always @* begin
    rdata_next = {`DCC_DATA_W{1'b0}};
    if (bus_rd) begin
      if (sel_mode) begin
        rdata_next = mode_reg & `DCC_MODE_IMPL_MASK;
      end else if (sel_value0) begin
        rdata_next = value0_reg;
      end else if (sel_value1) begin
        rdata_next = value1_reg;
      end else if (sel_status) begin
        rdata_next = status_word;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      bus_rdata <= {`DCC_DATA_W{1'b0}};
    end else begin
      bus_rdata <= rdata_next;
    end
  end
endmodule
`default_nettype wire

// >>> test/dcc_checker.sv
// Port assertions for the converter control
`timescale 1ns/1ns
`default_nettype none
`include "dcc_regs.vh"
module dcc_checker #(
  parameter CODE_W = 8
) (
  input wire clk,
  input wire rst,
  input wire [`DCC_ADDR_W-1:0] bus_addr,
  input wire [`DCC_DATA_W-1:0] bus_wdata,
  input wire [`DCC_DATA_W-1:0] bus_wmask,
  input wire bus_wr,
  input wire bus_rd,
  input wire [`DCC_DATA_W-1:0] bus_rdata,
  input wire timer_a_compare_event,
  input wire timer_b_compare_event,
  input wire stop_mode_req,
  input wire [CODE_W-1:0] analog_out_ch0_code,
  input wire [CODE_W-1:0] analog_out_ch1_code,
  input wire analog_out_ch0_hiz,
  input wire analog_out_ch1_hiz,
  input wire conv_ch0_pulse,
  input wire conv_ch1_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr0;
    bus_wr && bus_addr == `DCC_OFF_VALUE_CH0 && &bus_wmask && !timer_a_compare_event ##1 conv_ch0_pulse;
  endsequence
  sequence s_wr1;
    bus_wr && bus_addr == `DCC_OFF_VALUE_CH1 && &bus_wmask && !timer_b_compare_event ##1 conv_ch1_pulse;
  endsequence
  sequence s_stop;
    stop_mode_req [*4];
  endsequence
  sequence s_run;
    !stop_mode_req [*4];
  endsequence
  property p_rd_idle; !$past(bus_rd) |-> bus_rdata == 8'h00; endproperty
  property p_rsv; bus_rd && bus_addr == `DCC_OFF_MODE |=> (bus_rdata & 8'hCC) == 8'h00; endproperty
  property p_hold0; !conv_ch0_pulse |-> $stable(analog_out_ch0_code); endproperty
  property p_hold1; !conv_ch1_pulse |-> $stable(analog_out_ch1_code); endproperty
  property p_wr0; s_wr0 |-> analog_out_ch0_code == $past(bus_wdata); endproperty
  property p_wr1; s_wr1 |-> analog_out_ch1_code == $past(bus_wdata); endproperty
  property p_stop; s_stop |-> analog_out_ch0_hiz && analog_out_ch1_hiz && !conv_ch0_pulse && !conv_ch1_pulse; endproperty
  property p_run; s_run |-> !analog_out_ch0_hiz && !analog_out_ch1_hiz; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  a_rsv: assert property (p_rsv) else $error("reserved mode bits set");
  a_hold0: assert property (p_hold0) else $error("code 0 moved");
  a_hold1: assert property (p_hold1) else $error("code 1 moved");
  a_wr0: assert property (p_wr0) else $error("code 0 not written value");
  a_wr1: assert property (p_wr1) else $error("code 1 not written value");
  a_stop: assert property (p_stop) else $error("active in stop");
  a_run: assert property (p_run) else $error("high impedance outside stop");
endmodule
bind dcc_top dcc_checker #(.CODE_W(CODE_W)) u_chk (.clk(clk), .rst(rst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wmask(bus_wmask), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .timer_a_compare_event(timer_a_compare_event),
  .timer_b_compare_event(timer_b_compare_event), .stop_mode_req(stop_mode_req),
  .analog_out_ch0_code(analog_out_ch0_code), .analog_out_ch1_code(analog_out_ch1_code),
  .analog_out_ch0_hiz(analog_out_ch0_hiz), .analog_out_ch1_hiz(analog_out_ch1_hiz),
  .conv_ch0_pulse(conv_ch0_pulse), .conv_ch1_pulse(conv_ch1_pulse));
`default_nettype wire

// >>> test/dcc_timer_model.sv
// Timer compare event source for both real-time triggers
`timescale 1ns/1ns
`default_nettype none
module dcc_timer_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic run_a,
  input wire logic run_b,
  output logic timer_a_compare_event,
  output logic timer_b_compare_event
);
  // One compare pulse per request cycle, none while reset is high
  always @(posedge clk) begin
    timer_a_compare_event <= run_a && !rst;
    timer_b_compare_event <= run_b && !rst;
  end
endmodule
`default_nettype wire

// >>> test/dcc_top_test.sv
// Self-checking bench for the converter control
`timescale 1ns/1ns
`default_nettype none
`include "dcc_regs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("Error at %0t: got %h want %h", $time, a, b); end end
module dcc_top_test;
  localparam logic [31:0] mr = `DCC_OFF_MODE;
  logic clk = 0;
  logic rst = 1;
  logic [31:0] addr = 0;
  logic [7:0] wdata = 0, wmask = 0, rdata, d, c0, c1;
  logic wr = 0, rd = 0, run_a = 0, run_b = 0, stop = 0, ta, tb, h0, h1, p0, p1;
  int fail_count = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  dcc_top #(.CODE_W(8), .SETTLE_CYCLES(5)) DUT (.clk(clk), .rst(rst), .bus_addr(addr),
    .bus_wdata(wdata), .bus_wmask(wmask), .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata),
    .timer_a_compare_event(ta), .timer_b_compare_event(tb), .stop_mode_req(stop),
    .analog_out_ch0_code(c0), .analog_out_ch1_code(c1), .analog_out_ch0_hiz(h0),
    .analog_out_ch1_hiz(h1), .conv_ch0_pulse(p0), .conv_ch1_pulse(p1));
  dcc_timer_model tm (.clk(clk), .rst(rst), .run_a(run_a), .run_b(run_b),
    .timer_a_compare_event(ta), .timer_b_compare_event(tb));
  function automatic logic [8:0] cv(input int c);
    return c ? {p1, c1} : {p0, c0};
  endfunction
  function automatic logic [31:0] va(input int c);
    return c ? `DCC_OFF_VALUE_CH1 : `DCC_OFF_VALUE_CH0;
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic w(input logic [31:0] a, input logic [7:0] v, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wmask <= m;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic r(input logic [31:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 d = rdata;
  endtask
  task automatic fire(input int c);
    @(posedge clk);
    if (c) run_b <= 1;
    else run_a <= 1;
    @(posedge clk);
    run_a <= 0;
    run_b <= 0;
  endtask
  task automatic wait_conv(input int c);
    int n = 0;
    #1;
    while (cv(c) < 9'h100 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 8) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic t_regs;
    r(mr);
    `CHK(d, `DCC_MODE_RESET)
    r(va(0));
    `CHK(d, `DCC_VALUE_RESET)
    r(va(1));
    `CHK(d, `DCC_VALUE_RESET)
    r(32'hFFFFF284);
    `CHK(d, 8'h00)
    w(mr, 8'h03, 8'hFF);
    w(mr, 8'hFF, 8'hFF);
    r(mr);
    `CHK(d, 8'h33)
    w(mr, 8'h00, 8'h10);
    r(mr);
    `CHK(d, 8'h23)
    w(mr, 8'h03, 8'hFF);
    w(va(0), 8'h5A, 8'h0F);
    r(va(0));
    `CHK(d, 8'h00)
    $display("registers done");
  endtask
  task automatic t_normal(input int c);
    w(mr, 8'h00, 8'hFF);
    w(va(c), 8'hA5, 8'hFF);
    #1 `CHK(cv(c), 9'h000)
    w(mr, c ? 8'h20 : 8'h10, 8'hFF);
    wait_conv(c);
    `CHK(cv(c), 9'h1A5)
    w(va(c), 8'hFF, 8'hFF);
    #1 `CHK(cv(c), 9'h1FF)
    repeat (3) @(posedge clk);
    #1 `CHK(cv(c), 9'h0FF)
    w(mr, 8'h00, 8'hFF);
    $display("normal %0d done", c);
  endtask
  task automatic t_rt(input int c);
    logic [7:0] md;
    md = c ? 8'h02 : 8'h01;
    w(mr, md, 8'hFF);
    w(va(c), 8'h81, 8'hFF);
    w(mr, md | (md << 4), 8'hFF);
    fire(1 - c);
    repeat (3) @(posedge clk);
    #1 `CHK(cv(c), 9'h0FF)
    fire(c);
    wait_conv(c);
    `CHK(cv(c), 9'h181)
    w(va(c), 8'h7E, 8'hFF);
    #1 `CHK(cv(c), 9'h081)
    fire(c);
    wait_conv(c);
    `CHK(cv(c), 9'h17E)
    w(mr, md, 8'hFF);
    w(mr, 8'h00, 8'hFF);
    $display("real-time %0d done", c);
  endtask
  task automatic t_stop;
    w(mr, 8'h10, 8'hFF);
    repeat (3) @(posedge clk);
    stop <= 1;
    repeat (4) @(posedge clk);
    #1 `CHK(h0, 1'b1)
    `CHK(h1, 1'b1)
    w(va(0), 8'h11, 8'hFF);
    #1 `CHK(p0, 1'b0)
    r(`DCC_OFF_STATUS);
    `CHK(d, 8'h80)
    @(posedge clk);
    stop <= 0;
    repeat (4) @(posedge clk);
    #1 `CHK(h0, 1'b0)
    `CHK(h1, 1'b0)
    w(va(0), 8'h22, 8'hFF);
    #1 `CHK(cv(0), 9'h122)
    $display("stop done");
  endtask
  task automatic t_status;
    w(mr, 8'h00, 8'hFF);
    w(mr, 8'h01, 8'hFF);
    w(mr, 8'h11, 8'hFF);
    // Value write lands in the same cycle as the timer event
    fork
      fire(0);
      begin
        @(posedge clk);
        w(va(0), 8'h3C, 8'hFF);
      end
    join
    #1 `CHK(cv(0), 9'h122)
    r(`DCC_OFF_STATUS);
    `CHK(d, 8'h11)
    w(`DCC_OFF_STATUS, 8'h10, 8'h00);
    r(`DCC_OFF_STATUS);
    `CHK(d, 8'h11)
    w(`DCC_OFF_STATUS, 8'h10, 8'h10);
    r(`DCC_OFF_STATUS);
    `CHK(d, 8'h05)
    w(mr, 8'h01, 8'hFF);
    w(mr, 8'h00, 8'hFF);
    $display("status done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    t_regs();
    t_normal(0);
    t_normal(1);
    t_rt(0);
    t_rt(1);
    t_stop();
    t_status();
    give_verdict();
  end
endmodule
`default_nettype wire
